//--- src/flg_map.svh
// Register offsets, field positions, reset values and timing figures of the flash lock guard.
`ifndef FLG_MAP_SVH
`define FLG_MAP_SVH

`define FLG_OFF_MODE 8'h00
`define FLG_OFF_CMD 8'h04
`define FLG_OFF_STAT 8'h08
`define FLG_OFF_LOCK 8'h0C

`define FLG_MODE_LOCK_ERROR_FLAG_IE 0
`define FLG_MODE_RST 32'h0000_0000

`define FLG_CMD_KEY_LSB 24
`define FLG_CMD_PAGE_LSB 8
`define FLG_CMD_CODE_LSB 0
`define FLG_CMD_KEY 8'h5A
`define FLG_CODE_PROG_ERASE 4'h1
`define FLG_CODE_SET_LOCK 4'h2
`define FLG_CODE_PROG 4'h3
`define FLG_CODE_CLR_LOCK 4'h4
`define FLG_CODE_ERASE_ALL 4'h8

`define FLG_STAT_READY 0
`define FLG_STAT_LOCK_ERROR_FLAG 2
`define FLG_STAT_KEYE 3

`define FLG_CLK_MHZ 10
`define FLG_T_PROG_ERASE_US 6000
`define FLG_T_PROG_US 3000
`define FLG_T_ERASE_ALL_US 15000

`endif

//--- src/flg_pkg.sv
// Types shared by the flash lock guard modules.
package flg_pkg;
    typedef enum logic [1:0] {
        FLG_OP_PROG_ERASE,
        FLG_OP_PROG,
        FLG_OP_ERASE_ALL
    } flg_op_t;

    typedef struct packed {
        flg_op_t op;
        logic [15:0] page;
    } flg_req_t;
endpackage

//--- src/flg_busy_timer.sv
// Busy countdown that keeps the flash sequencer occupied for one operation.
module flg_busy_timer #(
    parameter int CW = 18
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [CW-1:0] load,
    output logic busy,
    output logic done
);
    logic [CW-1:0] cnt_reg;

    // A start is only issued while idle, so a running count is never reloaded.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                cnt_reg <= load;
                busy <= 1'b1;
            end else if (busy) begin
                if (cnt_reg <= CW'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_reg <= cnt_reg - CW'(1);
            end
        end
    end
endmodule // flg_busy_timer

//--- src/flg_guard.sv
// Flash lock region guard: APB registers, lock bits and the command sequencer.
`include "flg_map.svh"

module flg_guard
    import flg_pkg::*;
#(
    parameter int LOCK_BITS = 16,
    parameter int PAGES_PER_REGION = 64,
    parameter int PAGE_BYTES = 256,
    parameter int BANK_PAGES = 1024,
    parameter int PROG_ERASE_CYC = `FLG_T_PROG_ERASE_US * `FLG_CLK_MHZ,
    parameter int PROG_CYC = `FLG_T_PROG_US * `FLG_CLK_MHZ,
    parameter int ERASE_ALL_CYC = `FLG_T_ERASE_ALL_US * `FLG_CLK_MHZ
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic erase_pin,
    input wire logic [LOCK_BITS-1:0] nv_lock_in,
    output logic [LOCK_BITS-1:0] nv_lock_out,
    output logic irq,
    output flg_req_t flash_req,
    output logic flash_start,
    output logic flash_busy
);
    localparam int CW = 18;
    localparam int RW = (LOCK_BITS > 1) ? $clog2(LOCK_BITS) : 1;
    // Region size in bytes; its kilobyte count is shown to software in the lock register's upper half.
    localparam int REGION_BYTES = PAGES_PER_REGION * PAGE_BYTES;
    localparam logic [15:0] REGION_KB = 16'(REGION_BYTES / 1024);

    logic erase_meta_reg;
    logic erase_sync_reg;
    logic nv_loaded_reg;
    logic [LOCK_BITS-1:0] lock_reg;
    logic mode_ie_reg;
    logic lock_error_flag_reg;
    logic keye_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    flg_req_t req_reg;
    logic start_reg;
    logic tmr_busy;
    logic tmr_done;
    logic [CW-1:0] tmr_load;
    logic [CW-1:0] busy_len_reg;

    logic acc;
    logic wr_cmd;
    logic rd_stat;
    logic key_ok;
    logic [3:0] code;
    logic [15:0] page;
    logic [15:0] bank_page;
    logic [15:0] region;
    logic in_range;
    logic region_locked;
    logic any_locked;
    logic cmd_go;
    logic is_prog;
    logic is_erase_all;
    logic abort_lock;
    logic set_lock;
    logic clr_lock;
    logic mapped;
    logic [31:0] rd_data;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign flash_req = req_reg;
    assign flash_start = start_reg;
    assign flash_busy = tmr_busy;
    assign nv_lock_out = lock_reg;

    // The erase pin is asynchronous to clk, so it passes two flops before use.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            erase_meta_reg <= 1'b0;
            erase_sync_reg <= 1'b0;
        end else begin
            erase_meta_reg <= erase_pin;
            erase_sync_reg <= erase_meta_reg;
        end
    end

    // An access completes on the second access-phase cycle, when pready is high.
    assign acc = psel && penable && pready_reg;
    assign wr_cmd = acc && pwrite && (paddr == `FLG_OFF_CMD);
    assign rd_stat = acc && !pwrite && (paddr == `FLG_OFF_STAT);
    assign mapped = (paddr == `FLG_OFF_MODE) || (paddr == `FLG_OFF_CMD) ||
                    (paddr == `FLG_OFF_STAT) || (paddr == `FLG_OFF_LOCK);

    // Command fields and region decode; the page is taken modulo BANK_PAGES, so every bank maps onto the same regions.
    assign key_ok = pwdata[`FLG_CMD_KEY_LSB +: 8] == `FLG_CMD_KEY;
    assign code = pwdata[`FLG_CMD_CODE_LSB +: 4];
    assign page = pwdata[`FLG_CMD_PAGE_LSB +: 16];
    assign bank_page = 16'(page % BANK_PAGES);
    assign region = 16'(bank_page / PAGES_PER_REGION);
    assign in_range = region < 16'(LOCK_BITS);
    assign region_locked = in_range && lock_reg[region[RW-1:0]];
    assign any_locked = |lock_reg;

    // A command is acted on only with the key, while idle and after the lock bits are loaded.
    assign cmd_go = wr_cmd && key_ok && !tmr_busy && nv_loaded_reg;
    assign is_prog = (code == `FLG_CODE_PROG_ERASE) || (code == `FLG_CODE_PROG);
    assign is_erase_all = code == `FLG_CODE_ERASE_ALL;
    // Full erase is refused while any region is locked, as it would touch them all.
    assign abort_lock = cmd_go && ((is_prog && region_locked) || (is_erase_all && any_locked));
    assign set_lock = cmd_go && (code == `FLG_CODE_SET_LOCK) && in_range;
    assign clr_lock = cmd_go && (code == `FLG_CODE_CLR_LOCK) && in_range;

    // Lock bits live in non-volatile cells outside; they are reloaded once after reset.
    // Erase pin wins over any command in the same cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_reg <= '0;
            nv_loaded_reg <= 1'b0;
        end else begin
            nv_loaded_reg <= 1'b1;
            if (erase_sync_reg) begin
                lock_reg <= '0;
            end else if (!nv_loaded_reg) begin
                lock_reg <= nv_lock_in;
            end else if (set_lock) begin
                lock_reg[region[RW-1:0]] <= 1'b1;
            end else if (clr_lock) begin
                lock_reg[region[RW-1:0]] <= 1'b0;
            end
        end
    end

    // Mode register: the lock error interrupt enable.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_ie_reg <= 1'(`FLG_MODE_RST >> `FLG_MODE_LOCK_ERROR_FLAG_IE);
        end else if (acc && pwrite && (paddr == `FLG_OFF_MODE)) begin
            mode_ie_reg <= pwdata[`FLG_MODE_LOCK_ERROR_FLAG_IE];
        end
    end

    // Sticky error flags; a new error in the clearing read cycle stays set.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_error_flag_reg <= 1'b0;
            keye_reg <= 1'b0;
        end else begin
            if (abort_lock) begin
                lock_error_flag_reg <= 1'b1;
            end else if (rd_stat) begin
                lock_error_flag_reg <= 1'b0;
            end
            if (wr_cmd && !key_ok) begin
                keye_reg <= 1'b1;
            end else if (rd_stat) begin
                keye_reg <= 1'b0;
            end
        end
    end

    // The interrupt follows the flag only while software has enabled it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= lock_error_flag_reg && mode_ie_reg;
        end
    end

    // Operation start toward the array; an aborted command never reaches it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            start_reg <= 1'b0;
            req_reg <= '{op: FLG_OP_PROG_ERASE, page: 16'h0000};
        end else begin
            start_reg <= 1'b0;
            if (cmd_go && (is_prog || is_erase_all) && !abort_lock) begin
                start_reg <= 1'b1;
                req_reg.page <= page;
                case (code)
                    `FLG_CODE_PROG_ERASE: req_reg.op <= FLG_OP_PROG_ERASE;
                    `FLG_CODE_PROG: req_reg.op <= FLG_OP_PROG;
                    default: req_reg.op <= FLG_OP_ERASE_ALL;
                endcase
            end
        end
    end

    // Busy time chosen from the operation being started.
    always_comb begin
        case (req_reg.op)
            FLG_OP_PROG_ERASE: tmr_load = CW'(PROG_ERASE_CYC);
            FLG_OP_PROG: tmr_load = CW'(PROG_CYC);
            FLG_OP_ERASE_ALL: tmr_load = CW'(ERASE_ALL_CYC);
            default: tmr_load = CW'(PROG_CYC);
        endcase
    end

    flg_busy_timer #(
        .CW(CW)
    ) u_timer (
        .clk(clk),
        .resetn(resetn),
        .start(start_reg),
        .load(tmr_load),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // Cycle count of the running operation, kept apart from the timer so the checks measure it independently.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_len_reg <= '0;
        end else if (start_reg) begin
            busy_len_reg <= '0;
        end else if (tmr_busy) begin
            busy_len_reg <= busy_len_reg + CW'(1);
        end
    end

    // Read data mux; unmapped addresses read zero.
    always_comb begin
        rd_data = 32'h0000_0000;
        case (paddr)
            `FLG_OFF_MODE: rd_data[`FLG_MODE_LOCK_ERROR_FLAG_IE] = mode_ie_reg;
            `FLG_OFF_STAT: begin
                // Ready also drops for the cycle in which a start is in flight.
                rd_data[`FLG_STAT_READY] = !tmr_busy && !start_reg;
                rd_data[`FLG_STAT_LOCK_ERROR_FLAG] = lock_error_flag_reg;
                rd_data[`FLG_STAT_KEYE] = keye_reg;
            end
            `FLG_OFF_LOCK: begin
                rd_data[LOCK_BITS-1:0] = lock_reg;
                rd_data[31:16] = REGION_KB;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // APB answer: one wait state, then pready for one cycle with data and error.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= psel && penable && !pready_reg;
            pslverr_reg <= psel && penable && !pready_reg && !mapped;
            if (psel && penable && !pready_reg) begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end

    // Checks on the behaviour above.
    sequence s_locked_cmd;
        cmd_go && is_prog && region_locked;
    endsequence

    chk_abort_flag: assert property (@(posedge clk) disable iff (!resetn)
        s_locked_cmd |=> lock_error_flag_reg && !start_reg)
        else $error("locked command was not aborted");

    chk_erase_all_abort: assert property (@(posedge clk) disable iff (!resetn)
        cmd_go && is_erase_all && any_locked |=> lock_error_flag_reg && !start_reg)
        else $error("full erase ran over locked regions");

    chk_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
        irq_reg == $past(lock_error_flag_reg && mode_ie_reg))
        else $error("interrupt does not follow enabled lock error");

    chk_set_lock: assert property (@(posedge clk) disable iff (!resetn)
        set_lock && !erase_sync_reg |=> lock_reg[$past(region[RW-1:0])])
        else $error("set lock did not lock region");

    chk_clear_lock: assert property (@(posedge clk) disable iff (!resetn)
        clr_lock && !erase_sync_reg |=> !lock_reg[$past(region[RW-1:0])])
        else $error("clear lock did not release region");

    chk_erase_pin: assert property (@(posedge clk) disable iff (!resetn)
        erase_sync_reg |=> lock_reg == '0)
        else $error("erase pin left lock bits set");

    chk_load_once: assert property (@(posedge clk) disable iff (!resetn)
        resetn && !nv_loaded_reg && !erase_sync_reg |=> lock_reg == $past(nv_lock_in))
        else $error("stored lock bits were not reloaded");

    chk_key_gate: assert property (@(posedge clk) disable iff (!resetn)
        wr_cmd && !key_ok && nv_loaded_reg && !erase_sync_reg |=> !start_reg && keye_reg && $stable(lock_reg))
        else $error("command without key had an effect");

    sequence s_done_op(flg_op_t o);
        tmr_done && req_reg.op == o;
    endsequence

    chk_prog_erase_time: assert property (@(posedge clk) disable iff (!resetn)
        s_done_op(FLG_OP_PROG_ERASE) |-> busy_len_reg == CW'(PROG_ERASE_CYC))
        else $error("program with erase has wrong busy time");

    chk_prog_time: assert property (@(posedge clk) disable iff (!resetn)
        s_done_op(FLG_OP_PROG) |-> busy_len_reg == CW'(PROG_CYC))
        else $error("program has wrong busy time");

    chk_erase_all_time: assert property (@(posedge clk) disable iff (!resetn)
        s_done_op(FLG_OP_ERASE_ALL) |-> busy_len_reg == CW'(ERASE_ALL_CYC))
        else $error("full erase has wrong busy time");

    chk_start_busy: assert property (@(posedge clk) disable iff (!resetn)
        start_reg |=> tmr_busy && busy_len_reg == '0)
        else $error("operation start did not make the array busy");

    chk_stat_clear: assert property (@(posedge clk) disable iff (!resetn)
        rd_stat && !abort_lock |=> !lock_error_flag_reg)
        else $error("status read did not clear lock error");

    chk_done_ready: assert property (@(posedge clk) disable iff (!resetn)
        tmr_done |-> !tmr_busy)
        else $error("done while still busy");
endmodule // flg_guard

//--- tb/flg_flash_model.sv
// Far-side model of the flash guard: non-volatile lock storage and a start counter for the array.
module flg_flash_model
    import flg_pkg::*;
#(
    parameter int LOCK_BITS = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [LOCK_BITS-1:0] nv_lock_out,
    output logic [LOCK_BITS-1:0] nv_lock_in,
    input wire flg_req_t flash_req,
    input wire logic flash_start,
    output int starts
);
    timeunit 1ns;
    timeprecision 1ns;
    logic live = 1'b0;
    int start_cnt = 0;
    logic [LOCK_BITS-1:0] store = '0;

    // Storage keeps its bits through reset; it only follows the guard once the guard has reloaded them.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            live <= 1'b0;
        end else begin
            live <= 1'b1;
            if (live) store <= nv_lock_out;
        end
    end
    assign nv_lock_in = store;

    // Each array operation is counted so the bench can see aborted commands start nothing.
    always @(posedge clk) begin
        if (flash_start === 1'b1) start_cnt <= start_cnt + 1;
    end
    assign starts = start_cnt;
endmodule // flg_flash_model

//--- tb/flash_lock_region_guard_tb.sv
// Self-checking bench for the flash lock region guard.
`include "flg_map.svh"
module flash_lock_region_guard_tb
    import flg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, erase_pin = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, irq, flash_start, flash_busy, err;
    logic [15:0] nv_lock_in, nv_lock_out;
    flg_req_t flash_req;
    logic [31:0] prdata_sm, rdat_sm;
    logic pready_sm, irq_sm, flash_start_sm;
    logic [7:0] nv_lock_in_sm, nv_lock_out_sm;
    flg_req_t flash_req_sm;
    int starts_sm;
    int mismatches = 0, checks_done = 0, cyc = 0, busy_cyc = 0, starts, b0, s0;

    always #50 clk = ~clk;

    // Busy cycles are counted here so operation length is measured at the ports; a hang ends the run.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (flash_busy === 1'b1) busy_cyc <= busy_cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            stop_test();
        end
    end

    flg_guard #(.PROG_ERASE_CYC(20), .PROG_CYC(10), .ERASE_ALL_CYC(40)) i_flg_guard (.clk(clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .erase_pin(erase_pin), .nv_lock_in(nv_lock_in),
        .nv_lock_out(nv_lock_out), .irq(irq), .flash_req(flash_req), .flash_start(flash_start),
        .flash_busy(flash_busy));

    flg_flash_model #(.LOCK_BITS(16)) i_flg_flash_model (.clk(clk), .resetn(resetn), .nv_lock_out(nv_lock_out),
        .nv_lock_in(nv_lock_in), .flash_req(flash_req), .flash_start(flash_start), .starts(starts));

    // A second guard with eight tiny-page regions shares the bus and answers with the same timing.
    flg_guard #(.LOCK_BITS(8), .PAGES_PER_REGION(32), .PAGE_BYTES(64), .PROG_ERASE_CYC(20), .PROG_CYC(10),
        .ERASE_ALL_CYC(40)) i_flg_guard_small (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_sm), .pready(pready_sm), .pslverr(),
        .erase_pin(erase_pin), .nv_lock_in(nv_lock_in_sm), .nv_lock_out(nv_lock_out_sm), .irq(irq_sm),
        .flash_req(flash_req_sm), .flash_start(flash_start_sm), .flash_busy());

    flg_flash_model #(.LOCK_BITS(8)) i_flg_flash_model_small (.clk(clk), .resetn(resetn),
        .nv_lock_out(nv_lock_out_sm), .nv_lock_in(nv_lock_in_sm), .flash_req(flash_req_sm),
        .flash_start(flash_start_sm), .starts(starts_sm));

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer to both guards; the request stands until both pready outputs are sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 || pready_sm !== 1'b1) @(posedge clk);
        rdat = prdata;
        rdat_sm = prdata_sm;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmd(input logic [3:0] code, input logic [15:0] page);
        apb(1'b1, `FLG_OFF_CMD, {`FLG_CMD_KEY, page, 4'h0, code});
    endtask

    task automatic reset_dut();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // Starts an array operation, waits for ready and checks its length and the request handed on.
    task automatic run_op(input logic [3:0] code, input logic [15:0] page, input int n, input flg_op_t op);
        b0 = busy_cyc;
        s0 = starts;
        cmd(code, page);
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, `FLG_OFF_STAT, 32'h0000_0000);
            if (rdat[`FLG_STAT_READY] === 1'b1) break;
        end
        repeat (2) @(posedge clk);
        chk("busy cycles", 32'(n), 32'(busy_cyc - b0));
        chk("starts", 32'(s0 + 1), 32'(starts));
        chk("request op", 32'(op), 32'(flash_req.op));
        chk("request page", {16'h0000, page}, {16'h0000, flash_req.page});
    endtask

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        apb(1'b0, `FLG_OFF_MODE, 32'h0000_0000);
        chk("mode reset", `FLG_MODE_RST, rdat);
        apb(1'b0, `FLG_OFF_STAT, 32'h0000_0000);
        chk("status reset", 32'h0000_0001, rdat);
        apb(1'b0, `FLG_OFF_LOCK, 32'h0000_0000);
        chk("lock reset", 32'h0010_0000, rdat);
        chk("small lock reset", 32'h0002_0000, rdat_sm);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, err});
        $display("test reset values done");

        // Lock region 2 (region 4 in the small guard), then aim commands at it from both banks.
        cmd(`FLG_CODE_SET_LOCK, 16'd130);
        apb(1'b0, `FLG_OFF_LOCK, 32'h0000_0000);
        chk("lock set", 32'h0010_0004, rdat);
        chk("small lock set", 32'h0002_0010, rdat_sm);
        s0 = starts;
        cmd(`FLG_CODE_PROG, 16'd130);
        cmd(`FLG_CODE_PROG_ERASE, 16'd1154);
        repeat (3) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, `FLG_OFF_MODE, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk("irq enabled", 32'h1, {31'h0, irq});
        chk("aborted starts", 32'(s0), 32'(starts));
        chk("small irq enabled", 32'h1, {31'h0, irq_sm});
        chk("small aborted starts", 32'h0, 32'(starts_sm));
        apb(1'b0, `FLG_OFF_STAT, 32'h0000_0000);
        chk("lock error set", 32'h0000_0005, rdat);
        chk("small lock error", 32'h0000_0005, rdat_sm);
        apb(1'b0, `FLG_OFF_STAT, 32'h0000_0000);
        chk("lock error cleared", 32'h0000_0001, rdat);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        cmd(`FLG_CODE_ERASE_ALL, 16'd0);
        apb(1'b0, `FLG_OFF_STAT, 32'h0000_0000);
        chk("full erase aborted", 32'h0000_0005, rdat);
        apb(1'b1, `FLG_OFF_CMD, {8'hA5, 16'd130, 4'h0, `FLG_CODE_CLR_LOCK});
        apb(1'b0, `FLG_OFF_STAT, 32'h0000_0000);
        chk("key error", 32'h0000_0009, rdat);
        apb(1'b0, `FLG_OFF_LOCK, 32'h0000_0000);
        chk("lock kept", 32'h0010_0004, rdat);
        $display("test lock abort done");

        // Locks come back from storage after a reset.
        reset_dut();
        apb(1'b0, `FLG_OFF_LOCK, 32'h0000_0000);
        chk("lock after reset", 32'h0010_0004, rdat);
        chk("small lock after reset", 32'h0002_0010, rdat_sm);
        cmd(`FLG_CODE_CLR_LOCK, 16'd130);
        apb(1'b0, `FLG_OFF_LOCK, 32'h0000_0000);
        chk("lock cleared", 32'h0010_0000, rdat);
        chk("small lock cleared", 32'h0002_0000, rdat_sm);
        run_op(`FLG_CODE_PROG_ERASE, 16'd130, 20, FLG_OP_PROG_ERASE);
        run_op(`FLG_CODE_PROG, 16'd1023, 10, FLG_OP_PROG);
        run_op(`FLG_CODE_ERASE_ALL, 16'd0, 40, FLG_OP_ERASE_ALL);
        $display("test operation timing done");

        // First and last regions locked (only the first in the small guard), then the erase pin wipes them.
        cmd(`FLG_CODE_SET_LOCK, 16'd0);
        cmd(`FLG_CODE_SET_LOCK, 16'd960);
        apb(1'b0, `FLG_OFF_LOCK, 32'h0000_0000);
        chk("edge regions", 32'h0010_8001, rdat);
        chk("small edge regions", 32'h0002_0001, rdat_sm);
        @(posedge clk);
        erase_pin <= 1'b1;
        repeat (5) @(posedge clk);
        apb(1'b0, `FLG_OFF_LOCK, 32'h0000_0000);
        chk("erase pin", 32'h0010_0000, rdat);
        chk("small erase pin", 32'h0002_0000, rdat_sm);
        erase_pin <= 1'b0;
        $display("test erase pin done");
        stop_test();
    end
endmodule // flash_lock_region_guard_tb
